//--- src/ascc_top.sv
`timescale 1ns/100ps
`include "ascc_params.svh"

// Overview of operation
// RULE1: select low enables output, high floats it
// RULE2: link ignored settle plus two edges after rise
// RULE3: host gives 11 to 16 clocks
// RULE4: continuous select needs exactly 16 clocks
// RULE5: fast continuous: done rise presents previous MSB
// RULE6: slow continuous: sixteenth fall presents previous MSB
// RULE7: slow means conversion ends before transfer
// RULE8: host gives eleventh rise before conversion ends
// RULE9: eleventh rise within 9.5 us of tenth fall
// RULE10: four address bits, MSB first, rising edges
// RULE11: codes 0 to 10 pick external inputs
// RULE12: codes 11 to 13 pick test voltages
// RULE13: sample from fourth fall, hold at tenth
// RULE14: ten bit successive approximation from 512 weight
// RULE15: select falling edge starts every mode
// RULE16: select fall mid cycle aborts, result kept
// RULE17: host avoids select fall near conversion end
// RULE18: result saturates at full scale and zero
// RULE19: nine remaining bits on next nine falls
// RULE20: done low at tenth fall, high when ready
// RULE21: output low from tenth fall onward
// RULE22: approximation steps run on core clock
module ascc_top (
   input  wire logic                      CORE_CLK,
   input  wire logic                      ARST_N,
   input  wire logic                      CE,
   input  wire logic                      SER_CLK,
   input  wire logic                      SEL_N,
   input  wire logic                      SER_ADDR,
   input  wire logic                      CMP_BELOW,
   output logic                           DOUT_O,
   output logic                           DOUT_OE,
   output logic                           DONE,
   output logic [3:0]                     MUX_SEL,
   output logic                           MUX_EN,
   output logic                           TEST_SEL,
   output logic                           SAMPLE,
   output ascc_pkg::ascc_result_type      DAC_CODE,
   output logic                           SLOW_MODE
);
   import ascc_pkg::*;

   localparam int WAIT_CYC = `ASCC_SEL_WAIT_CYC;
   localparam int STEP_CYC = `ASCC_STEP_CYC;
   localparam int CONV_MAX = 10 * STEP_CYC + 4;
   localparam int OFF_MAX  = `ASCC_SEL_WAIT_CYC + 4;

   function automatic logic in_span(input logic [3:0] n,
                                    input logic [3:0] lo,
                                    input logic [3:0] hi);
      in_span = (n >= lo) && (n <= hi);
   endfunction

   function automatic logic is_test_code(input logic [3:0] c);
      is_test_code = in_span(c, `ASCC_CH_TEST_MID, `ASCC_CH_TEST_HIGH);
   endfunction

   // ---------------- core domain: select handling ----------------
   logic            sel_q1;
   logic            sel_q2;
   logic            sel_d;
   logic            link_en;
   logic [4:0]      wait_cnt;
   logic            link_rst_n;
   logic            sel_low;
   logic            sel_fall_ev;

   assign sel_low     = !sel_q2;
   assign sel_fall_ev = sel_d && !sel_q2;

   always_ff @(posedge CORE_CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         sel_q1 <= 1'b1;
         sel_q2 <= 1'b1;
         sel_d  <= 1'b1;
      end else if (CE) begin
         sel_q1 <= SEL_N;
         sel_q2 <= sel_q1;
         sel_d  <= sel_q2;
      end
   end

   // link follows select only after it has stayed put long enough,
   // so short glitches on the select pin never reach the link side
   always_ff @(posedge CORE_CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         link_en  <= 1'b0;
         wait_cnt <= 5'h00;
      end else if (CE) begin
         if (link_en == sel_low) begin
            wait_cnt <= 5'h00;
         end else if (wait_cnt >= 5'(WAIT_CYC - 1)) begin
            link_en  <= sel_low;                              // [RULE2]
            wait_cnt <= 5'h00;
         end else begin
            wait_cnt <= wait_cnt + 5'h01;
         end
      end
   end

   always_ff @(posedge CORE_CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         DOUT_OE <= 1'b0;
      end else if (CE) begin
         DOUT_OE <= sel_low;                                  // [RULE1]
      end
   end

   // the serial clock is idle while link_en changes, so the release
   // of this reset cannot race a link clock edge
   assign link_rst_n = ARST_N && link_en;

   // ---------------- link domain ----------------
   logic [3:0]      rcnt;
   logic [3:0]      fcnt;
   logic [3:0]      addr;
   logic            link_bit;
   logic            samp_l;
   logic            post_l;
   logic [3:0]      next_fcnt;
   ascc_result_type result;

   assign next_fcnt = fcnt + 4'h1;

   always_ff @(posedge SER_CLK or negedge link_rst_n) begin
      if (!link_rst_n) begin
         rcnt <= 4'h0;
         addr <= 4'h0;
      end else begin
         rcnt <= rcnt + 4'h1;
         if (rcnt < `ASCC_ADDR_EDGES) begin
            addr <= {addr[2:0], SER_ADDR};                    // [RULE10]
         end
      end
   end

   // counter wraps after sixteen falls, which restarts the next
   // frame when select stays low
   // result is read without a synchroniser: it only changes after the
   // tenth fall, when the shift phase is already over
   always_ff @(negedge SER_CLK or negedge link_rst_n) begin
      if (!link_rst_n) begin
         fcnt     <= 4'h0;
         samp_l   <= 1'b0;
         post_l   <= 1'b0;
         link_bit <= 1'b0;
      end else begin
         fcnt   <= next_fcnt;
         samp_l <= in_span(next_fcnt, `ASCC_SAMPLE_FALL,
                           `ASCC_HOLD_FALL - 4'h1);           // [RULE13]
         post_l <= (next_fcnt >= `ASCC_HOLD_FALL);
         if (in_span(next_fcnt, 4'h1, `ASCC_LAST_DATA_FALL)) begin
            link_bit <= result[4'h9 - next_fcnt];             // [RULE19]
         end else begin
            link_bit <= 1'b0;                                 // [RULE21]
         end
      end
   end

   // ---------------- core domain: link events ----------------
   logic samp_q1;
   logic samp_q2;
   logic samp_d;
   logic post_q1;
   logic post_q2;
   logic post_d;
   logic cmp_q1;
   logic cmp_q2;
   logic samp_rise;
   logic post_rise;

   always_ff @(posedge CORE_CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         samp_q1 <= 1'b0;
         samp_q2 <= 1'b0;
         samp_d  <= 1'b0;
         post_q1 <= 1'b0;
         post_q2 <= 1'b0;
         post_d  <= 1'b0;
         cmp_q1  <= 1'b0;
         cmp_q2  <= 1'b0;
      end else if (CE) begin
         samp_q1 <= samp_l;
         samp_q2 <= samp_q1;
         samp_d  <= samp_q2;
         post_q1 <= post_l;
         post_q2 <= post_q1;
         post_d  <= post_q2;
         cmp_q1  <= CMP_BELOW;
         cmp_q2  <= cmp_q1;
      end
   end

   assign samp_rise = samp_q2 && !samp_d && link_en;
   assign post_rise = post_q2 && !post_d && link_en;

   // ---------------- sequencer and approximation ----------------
   ascc_state_type  state;
   ascc_result_type mask;
   logic [2:0]      step_cnt;
   logic            lead;

   always_ff @(posedge CORE_CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         state     <= ST_IDLE;
         DONE      <= 1'b1;
         SAMPLE    <= 1'b0;
         MUX_SEL   <= 4'h0;
         DAC_CODE  <= `ASCC_RES_RESET;
         mask      <= `ASCC_RES_RESET;
         step_cnt  <= 3'h0;
         result    <= `ASCC_RES_RESET;
         SLOW_MODE <= 1'b0;
      end else if (CE) begin
         if (sel_fall_ev && state != ST_IDLE) begin
            state  <= ST_IDLE;                                // [RULE16]
            DONE   <= 1'b1;
            SAMPLE <= 1'b0;
         end else begin
            case (state)
               ST_IDLE: begin
                  if (samp_rise) begin
                     MUX_SEL <= addr;                         // [RULE11]
                     SAMPLE  <= 1'b1;                         // [RULE13]
                     state   <= ST_SAMP;
                  end
               end
               ST_SAMP: begin
                  if (post_rise) begin
                     SAMPLE   <= 1'b0;                        // [RULE13]
                     DONE     <= 1'b0;                        // [RULE20]
                     DAC_CODE <= `ASCC_RES_MSB_WEIGHT;        // [RULE14]
                     mask     <= `ASCC_RES_MSB_WEIGHT;
                     step_cnt <= 3'h0;
                     state    <= ST_CONV;
                  end
               end
               ST_CONV: begin
                  // all-below drives every bit to one and all-above
                  // to zero, which gives the saturated codes [RULE18]
                  if (step_cnt == 3'(STEP_CYC - 1)) begin
                     step_cnt <= 3'h0;
                     if (mask[0]) begin
                        result    <= cmp_q2 ? DAC_CODE
                                            : (DAC_CODE & ~mask);
                        DONE      <= 1'b1;                    // [RULE20]
                        SLOW_MODE <= sel_low && post_q2;      // [RULE7]
                        state     <= ST_IDLE;
                     end else begin
                        DAC_CODE <= (cmp_q2 ? DAC_CODE
                                            : (DAC_CODE & ~mask))
                                    | (mask >> 1);            // [RULE14]
                        mask     <= mask >> 1;
                     end
                  end else begin
                     step_cnt <= step_cnt + 3'h1;             // [RULE22]
                  end
               end
               default: begin
                  state <= ST_IDLE;
               end
            endcase
         end
      end
   end

   always_comb begin
      MUX_EN   = MUX_SEL <= `ASCC_CH_TEST_HIGH;
      TEST_SEL = is_test_code(MUX_SEL);                       // [RULE12]
   end

   // lead bit is what the output shows before the first fall of a
   // frame: previous MSB after select fall or done rise, else low
   always_ff @(posedge CORE_CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         lead <= 1'b0;
      end else if (CE) begin
         if (sel_fall_ev) begin
            lead <= 1'b1;                                     // [RULE15]
         end else if (state == ST_CONV && step_cnt ==
                      3'(STEP_CYC - 1) && mask[0]) begin
            lead <= 1'b1;                                     // [RULE5]
         end else if (post_rise) begin
            lead <= 1'b0;
         end
      end
   end

   // with select low across frames the fall counter wraps to zero on
   // the sixteenth fall, handing the pin back to the lead bit
   always_comb begin
      if (fcnt == 4'h0) begin
         DOUT_O = lead && result[9];                          // [RULE6]
      end else begin
         DOUT_O = link_bit;
      end
   end

   // ---------------- checks ----------------
   a_oe_on_select: assert property (                          // [RULE1]
      @(posedge CORE_CLK) disable iff (!ARST_N)
      CE && $changed(sel_q2) |=> DOUT_OE == !$past(sel_q2))
      else $error("output enable does not follow select");

   a_link_off_delay: assert property (                        // [RULE2]
      @(posedge CORE_CLK) disable iff (!ARST_N || !CE)
      $rose(sel_q2) |-> link_en ##[1:OFF_MAX] !link_en)
      else $error("link not disabled after select rise");

   a_addr_shift_in: assert property (                         // [RULE10]
      @(posedge SER_CLK) disable iff (!link_rst_n)
      rcnt < 4'h4 |=> addr[0] == $past(SER_ADDR))
      else $error("address bit not captured");

   a_data_bits_out: assert property (                         // [RULE19]
      @(negedge SER_CLK) disable iff (!link_rst_n)
      fcnt >= 4'h1 && fcnt <= 4'h9 |-> link_bit == result[4'h9 - fcnt])
      else $error("wrong result bit shifted out");

   a_zero_tail: assert property (                             // [RULE21]
      @(negedge SER_CLK) disable iff (!link_rst_n)
      fcnt >= 4'ha |-> !link_bit && DOUT_O == 1'b0)
      else $error("output not low after tenth fall");

   a_done_low_hold: assert property (                         // [RULE20]
      @(posedge CORE_CLK) disable iff (!ARST_N || !CE)
      state == ST_SAMP && post_rise && !sel_fall_ev
      |=> !DONE && state == ST_CONV)
      else $error("done not lowered at hold");

   a_conv_bounded: assert property (                          // [RULE22]
      @(posedge CORE_CLK) disable iff (!ARST_N || !CE)
      $fell(DONE) |-> ##[1:CONV_MAX] DONE)
      else $error("conversion did not finish in time");

   a_abort_keeps: assert property (                           // [RULE16]
      @(posedge CORE_CLK) disable iff (!ARST_N)
      CE && sel_fall_ev && state != ST_IDLE
      |=> state == ST_IDLE && DONE && $stable(result))
      else $error("abort did not return to idle");

   a_lead_on_done: assert property (                          // [RULE5]
      @(posedge CORE_CLK) disable iff (!ARST_N || !CE)
      $rose(DONE) && $past(state) == ST_CONV |-> lead)
      else $error("previous MSB not presented at done");

   a_sample_window: assert property (                         // [RULE13]
      @(posedge CORE_CLK) disable iff (!ARST_N || !CE)
      state == ST_IDLE && samp_rise && !sel_fall_ev
      |=> SAMPLE ##0 MUX_SEL == $past(addr))
      else $error("sampling not started with new channel");

endmodule

//--- src/ascc_params.svh
`ifndef ASCC_PARAMS_SVH
`define ASCC_PARAMS_SVH

// core clock
`define ASCC_CORE_PERIOD_NS   10

// select settling interval before the extra two core edges
`define ASCC_SEL_SETTLE_NS    20
`define ASCC_SEL_SETTLE_CYC   \
   ((`ASCC_SEL_SETTLE_NS + `ASCC_CORE_PERIOD_NS - 1) / `ASCC_CORE_PERIOD_NS)
`define ASCC_SEL_EXTRA_EDGES  2
`define ASCC_SEL_WAIT_CYC     (`ASCC_SEL_SETTLE_CYC + `ASCC_SEL_EXTRA_EDGES)

// comparator settling per approximation step
`define ASCC_STEP_NS          40
`define ASCC_STEP_CYC         \
   ((`ASCC_STEP_NS + `ASCC_CORE_PERIOD_NS - 1) / `ASCC_CORE_PERIOD_NS)

// serial clock edge positions
`define ASCC_ADDR_EDGES       4'h4
`define ASCC_SAMPLE_FALL      4'h4
`define ASCC_HOLD_FALL        4'ha
`define ASCC_LAST_DATA_FALL   4'h9

// result layout
`define ASCC_RES_W            10
`define ASCC_RES_MSB_WEIGHT   10'h200
`define ASCC_RES_RESET        10'h000

// channel codes
`define ASCC_CH_LAST_EXT      4'ha
`define ASCC_CH_TEST_MID      4'hb
`define ASCC_CH_TEST_LOW      4'hc
`define ASCC_CH_TEST_HIGH     4'hd

`endif

//--- src/ascc_pkg.sv
package ascc_pkg;

   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_SAMP = 3'b010,
      ST_CONV = 3'b100
   } ascc_state_type;

   typedef logic [9:0] ascc_result_type;

endpackage

//--- sim/ascc_cmp_model.sv
`timescale 1ns/100ps
module ascc_cmp_model (
   input  ascc_pkg::ascc_result_type dac_code,
   input  logic [3:0]                mux_sel,
   input  logic [10:0]               vin_ext,
   output logic                      cmp_below
);
   import ascc_pkg::*;
   logic [10:0] vin;
   always_comb begin
      case (mux_sel)
         4'hb:    vin = 11'h200;
         4'hc:    vin = 11'h000;
         4'hd:    vin = 11'h3ff;
         default: vin = vin_ext;
      endcase
      // extra input bit lets a level sit above full scale
      cmp_below = (vin >= {1'b0, dac_code});
   end
endmodule

//--- sim/tb_top.sv
`timescale 1ns/100ps
module tb_top;
   import ascc_pkg::*;
   typedef struct packed {
      logic [3:0]  a;
      logic [4:0]  n;
      logic        s;
      logic [10:0] v;
   } ascc_row_type;
   logic            core_clk = 1'b0;
   logic            arst_n, ser_clk, sel_n, ser_addr, cmp_below, ce;
   logic            dout_o, dout_oe, done, mux_en, test_sel, sample;
   logic            slow_mode;
   logic [3:0]      mux_sel;
   logic [10:0]     vin_ext;
   ascc_result_type dac_code, prev, saved;
   int              error_cnt = 0;
   int              num_checks = 0;
   ascc_row_type    rows [9] = '{
      '{4'h0, 5'd16, 1'b0, 11'h123}, '{4'h1, 5'd11, 1'b1, 11'h2aa},
      '{4'h5, 5'd13, 1'b0, 11'h055}, '{4'ha, 5'd16, 1'b1, 11'h400},
      '{4'hb, 5'd12, 1'b0, 11'h111}, '{4'hc, 5'd11, 1'b1, 11'h3ff},
      '{4'hd, 5'd14, 1'b0, 11'h000}, '{4'he, 5'd16, 1'b0, 11'h1e5},
      '{4'h3, 5'd11, 1'b0, 11'h3ff}};

   always #5 core_clk = ~core_clk;

   ascc_top i_ascc_top (.CORE_CLK(core_clk), .ARST_N(arst_n), .CE(ce),
      .SER_CLK(ser_clk), .SEL_N(sel_n), .SER_ADDR(ser_addr),
      .CMP_BELOW(cmp_below), .DOUT_O(dout_o), .DOUT_OE(dout_oe),
      .DONE(done), .MUX_SEL(mux_sel), .MUX_EN(mux_en), .TEST_SEL(test_sel),
      .SAMPLE(sample), .DAC_CODE(dac_code), .SLOW_MODE(slow_mode));
   ascc_cmp_model i_ascc_cmp_model (.dac_code(dac_code), .mux_sel(mux_sel),
      .vin_ext(vin_ext), .cmp_below(cmp_below));

   task wrap_up;
      $display("checks %0d, mismatches %0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask

   task chk(input logic [10:0] seen, input logic [10:0] exp);
      num_checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
      end
   endtask

   task wait_done;
      int i;
      for (i = 0; i < 300 && done !== 1'b1; i++) begin
         @(posedge core_clk);
         #1;
      end
      if (done !== 1'b1) begin
         error_cnt++;
         $display("mismatch at %0t: done flag never rose", $time);
         wrap_up();
      end
   endtask

   function automatic ascc_result_type ideal(input logic [3:0] a,
                                             input logic [10:0] v);
      case (a)
         4'hb:    ideal = 10'h200;
         4'hc:    ideal = 10'h000;
         4'hd:    ideal = 10'h3ff;
         default: ideal = (v > 11'h3ff) ? 10'h3ff : v[9:0];
      endcase
   endfunction

   task frame(input logic [3:0] a, input int n, input bit s, input bit keep,
              input bit cont, input logic [10:0] v);
      int              k;
      ascc_result_type got, nexp;
      nexp = ideal(a, v);
      if (!cont) begin
         @(posedge core_clk) sel_n <= 1'b0;
         repeat (12) @(posedge core_clk);
         #1;
         chk(done, 1'b1);
      end
      wait_done();
      @(posedge core_clk) vin_ext <= v;
      #1;
      chk(dout_oe, 1'b1);
      got[9] = dout_o;
      // link clock gives n pulses inside the frame; the stray clock test also pulses it with select high
      for (k = 1; k <= n; k++) begin
         ser_addr = (k < 5) ? a[4-k] : 1'b0;
         #31 ser_clk = 1'b1;
         #32 ser_clk = 1'b0;
         #1;
         // after the sixteenth fall a finished result shows its MSB
         if (k < 10) got[9-k] = dout_o;
         else if (k == 16 && s) chk(dout_o, nexp[9]);
         else chk(dout_o, 1'b0);
         if (k == 3) chk(sample, 1'b0);
         if (k == 5) chk(sample, 1'b1);
         if (k == 11) chk(sample, 1'b0);
         if (k == 11) chk(done, 1'b0);
         if (k == 11 && s) wait_done();
      end
      chk(got, prev);
      chk(mux_sel, a);
      chk(mux_en, a <= 4'hd);
      chk(test_sel, a >= 4'hb && a <= 4'hd);
      if (!keep) begin
         @(posedge core_clk) sel_n <= 1'b1;
         wait_done();
         chk(slow_mode, s);
         repeat (8) @(posedge core_clk);
         #1;
         chk(dout_oe, 1'b0);
      end
      prev = nexp;
   endtask

   initial begin
      sel_n = 1'b1;
      ce = 1'b1;
      ser_clk = 1'b0;
      ser_addr = 1'b0;
      arst_n = 1'b0;
      vin_ext = 11'h000;
      prev = 10'h000;
      repeat (4) @(posedge core_clk);
      chk(done, 1'b1);
      chk(dout_oe, 1'b0);
      chk(dout_o, 1'b0);
      chk(sample, 1'b0);
      chk(dac_code, 10'h000);
      chk(mux_sel, 4'h0);
      chk(slow_mode, 1'b0);
      arst_n <= 1'b1;
      $display("reset test done");
      for (int r = 0; r < 9; r++) begin
         frame(rows[r].a, rows[r].n, rows[r].s, 1'b0, 1'b0, rows[r].v);
         $display("row %0d done", r);
      end
      // pulses with select high must not disturb the next frame
      ser_addr = 1'b1;
      repeat (4) begin
         #32 ser_clk = 1'b1;
         #32 ser_clk = 1'b0;
      end
      frame(4'h8, 12, 1'b0, 1'b0, 1'b0, 11'h2c7);
      $display("stray clock test done");
      frame(4'h2, 16, 1'b0, 1'b1, 1'b0, 11'h0f0);
      frame(4'h7, 16, 1'b1, 1'b1, 1'b1, 11'h31c);
      frame(4'h9, 16, 1'b0, 1'b0, 1'b1, 11'h0a5);
      $display("continuous select test done");
      saved = prev;
      frame(4'h4, 10, 1'b0, 1'b1, 1'b0, 11'h3a0);
      // abort lands well before the end of conversion
      @(posedge core_clk) sel_n <= 1'b1;
      repeat (10) @(posedge core_clk);
      prev = saved;
      frame(4'h6, 12, 1'b0, 1'b0, 1'b0, 11'h15e);
      $display("abort test done");
      // reset during a conversion raises done and clears trial code and result
      frame(4'h1, 10, 1'b0, 1'b1, 1'b0, 11'h155);
      repeat (5) @(posedge core_clk);
      #1;
      chk(done, 1'b0);
      @(posedge core_clk) arst_n <= 1'b0;
      sel_n <= 1'b1;
      repeat (4) @(posedge core_clk);
      #1;
      chk(done, 1'b1);
      chk(dac_code, 10'h000);
      chk(dout_oe, 1'b0);
      @(posedge core_clk) arst_n <= 1'b1;
      prev = 10'h000;
      frame(4'h3, 12, 1'b0, 1'b0, 1'b0, 11'h2e1);
      $display("mid-run reset test done");
      // a low enable freezes the core side, so a select fall goes unseen
      @(posedge core_clk) ce <= 1'b0;
      sel_n <= 1'b0;
      repeat (12) @(posedge core_clk);
      #1;
      chk(dout_oe, 1'b0);
      chk(done, 1'b1);
      @(posedge core_clk) sel_n <= 1'b1;
      repeat (4) @(posedge core_clk);
      ce <= 1'b1;
      $display("clock enable test done");
      wrap_up();
   end
endmodule
